/* design/conditional_branch_unit.sv */
// conditional_branch_unit: evaluates flag tests and updates the program counter
// assumes decoder, flags and program counter all run on clk_sys under reset
// assumes req and flags are steady from one falling edge to the next
// assumes the decoder holds a request through the flush cycle or drops it
// outputs: pc is the word address, taken and flush pulse for one cycle
// outputs: busy marks the cycle in which a new request is ignored

`timescale 1ns/1ps
`default_nettype none
module conditional_branch_unit
   import branch_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire branch_req_t req,
   input wire status_flags_t flags,
   output logic [15:0] pc,
   output logic taken,
   output logic flush,
   output logic busy
);

   // ==========================================================
   // condition evaluation
   // each flag test is formed once; the kind picks which one counts
   logic carry_clear_ok;
   logic carry_set_ok;
   logic negative_set_ok;
   logic negative_clear_ok;
   logic signed_ge_ok;
   logic cond;
   // flag tests; the flags are only read, never written back
   assign carry_clear_ok = ~flags.carry;
   assign carry_set_ok = flags.carry;
   assign negative_set_ok = flags.negative;
   assign negative_clear_ok = ~flags.negative;
   assign signed_ge_ok = ~(flags.negative ^ flags.overflow);
   // select the test for the kind in hand; unused codes never branch
   always_comb begin
      case (req.kind)
         BR_CARRY_CLEAR: cond = carry_clear_ok;
         BR_AT_LEAST: cond = carry_clear_ok;
         BR_BELOW: cond = carry_set_ok;
         BR_NEGATIVE: cond = negative_set_ok;
         BR_NONNEG: cond = negative_clear_ok;
         BR_SIGNED_GE: cond = signed_ge_ok;
         default: cond = 1'b0;
      endcase
   end

   // ==========================================================
   // state and program counter next values
   seq_state_t state_r, state_nxt;
   logic [15:0] pc_r, pc_nxt;
   logic taken_r, taken_nxt;
   logic flush_r, flush_nxt;
   wire logic [15:0] ofs_ext;
   logic go;
   // sign-extend the word offset so that a negative k steps backwards
   for (genvar b = 0; b < PC_W; b++) begin : g_ofs_ext
      if (b < OFS_W) begin : g_field
         assign ofs_ext[b] = req.offset[b];
      end else begin : g_sign
         assign ofs_ext[b] = req.offset[OFS_W - 1];
      end
   end
   // a branch is taken only when it is issued and its test holds
   assign go = req.valid && cond;
   // one-hot sequencer: a taken branch spends one extra cycle flushing
   always_comb begin
      state_nxt = state_r;
      pc_nxt = pc_r;
      taken_nxt = 1'b0;
      flush_nxt = 1'b0;
      case (state_r)
         ST_RUN: begin
            if (go) begin
               // taken: jump and drop the fetch that is already under way
               pc_nxt = pc_r + ofs_ext + PC_ONE;
               taken_nxt = 1'b1;
               flush_nxt = 1'b1;
               state_nxt = ST_FLUSH;
            end else if (req.valid) begin
               // not taken: carry on with the next word
               pc_nxt = pc_r + PC_ONE;
            end
         end
         ST_FLUSH: begin
            // a request seen here belongs to the discarded fetch
            state_nxt = ST_RUN;
         end
         default: state_nxt = ST_RUN;
      endcase
   end

   // registers only; flags are never written here
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_r <= ST_RUN;
         pc_r <= PC_RESET;
         taken_r <= 1'b0;
         flush_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         pc_r <= pc_nxt;
         taken_r <= taken_nxt;
         flush_r <= flush_nxt;
      end
   end
   // outputs come straight from the registers
   assign pc = pc_r;
   assign taken = taken_r;
   assign flush = flush_r;
   assign busy = flush_r;

   // ==========================================================
   // checks
   // named steps of a branch: issued, decided, flushing, settled
   sequence s_issue;
      state_r == ST_RUN && req.valid;
   endsequence
   sequence s_take;
      s_issue ##0 cond;
   endsequence
   sequence s_pass;
      s_issue ##0 !cond;
   endsequence
   sequence s_flush_step;
      flush_r && taken_r && state_r == ST_FLUSH;
   endsequence
   sequence s_settle;
      !flush_r && !taken_r && state_r == ST_RUN;
   endsequence

   // a taken branch lands on pc plus k plus one
   AST_TAKEN_PC: assert property (@(posedge clk_sys) disable iff (reset)
      s_take |=> pc_r == $past(pc_r) + $past(ofs_ext) + PC_ONE)
      else $error("taken branch pc wrong");

   // a branch that is not taken steps to the next word and raises nothing
   AST_UNTAKEN_PC: assert property (@(posedge clk_sys) disable iff (reset)
      s_pass |=> pc_r == $past(pc_r) + PC_ONE && !taken_r)
      else $error("untaken branch pc wrong");

   // carry clear kind is taken exactly when carry was clear at issue
   AST_CC: assert property (@(posedge clk_sys) disable iff (reset)
      s_issue ##0 (req.kind == BR_CARRY_CLEAR) |=> taken_r == !$past(flags.carry))
      else $error("carry clear decision wrong");

   // unsigned at-least kind decides exactly as carry clear does
   AST_SH_EQ_CC: assert property (@(posedge clk_sys) disable iff (reset)
      s_issue ##0 (req.kind == BR_AT_LEAST) |=> taken_r == !$past(flags.carry))
      else $error("at-least decision wrong");

   // unsigned below kind is taken exactly when carry was set
   AST_BELOW: assert property (@(posedge clk_sys) disable iff (reset)
      s_issue ##0 (req.kind == BR_BELOW) |=> taken_r == $past(flags.carry))
      else $error("below decision wrong");

   // negative kind is taken exactly when the negative flag was set
   AST_NEG: assert property (@(posedge clk_sys) disable iff (reset)
      s_issue ##0 (req.kind == BR_NEGATIVE) |=> taken_r == $past(flags.negative))
      else $error("negative decision wrong");

   // nonnegative kind is taken exactly when the negative flag was clear
   AST_NONNEG: assert property (@(posedge clk_sys) disable iff (reset)
      s_issue ##0 (req.kind == BR_NONNEG) |=> taken_r == !$past(flags.negative))
      else $error("nonnegative decision wrong");

   // signed at-least kind is taken when negative and overflow agree
   AST_SGE: assert property (@(posedge clk_sys) disable iff (reset)
      s_issue ##0 (req.kind == BR_SIGNED_GE) |=> taken_r == !($past(flags.negative) ^ $past(flags.overflow)))
      else $error("signed ge decision wrong");

   // unused kind codes always fall through
   AST_BAD_KIND: assert property (@(posedge clk_sys) disable iff (reset)
      s_issue ##0 (req.kind > BR_SIGNED_GE) |=> !taken_r && pc_r == $past(pc_r) + PC_ONE)
      else $error("unused kind branched");

   // a taken branch flushes for one cycle, then settles with pc held
   AST_TWO_CYCLE: assert property (@(posedge clk_sys) disable iff (reset)
      s_take |=> s_flush_step ##1 (s_settle ##0 $stable(pc_r)))
      else $error("taken branch not two cycles");

   // a request during the flush cycle is ignored
   AST_REFUSED: assert property (@(posedge clk_sys) disable iff (reset)
      (state_r == ST_FLUSH) |=> $stable(pc_r) && !flush_r)
      else $error("request accepted while flushing");

   // with nothing issued the program counter stays put
   AST_IDLE_HOLD: assert property (@(posedge clk_sys) disable iff (reset)
      (state_r == ST_RUN && !req.valid) |=> $stable(pc_r) && !taken_r)
      else $error("pc moved while idle");

   // taken and busy are single-cycle pulses
   AST_PULSE: assert property (@(posedge clk_sys) disable iff (reset)
      taken_r |=> !taken_r && !busy)
      else $error("taken pulse too long");

   // offset of minus one plus one lands on the branch itself
   AST_SELF_LOOP: assert property (@(posedge clk_sys) disable iff (reset)
      s_take ##0 (req.offset == 7'h7F) |=> $stable(pc_r))
      else $error("minus one offset not sign extended");

   // largest forward offset moves sixty-four words ahead
   AST_FWD_MAX: assert property (@(posedge clk_sys) disable iff (reset)
      s_take ##0 (req.offset == 7'h3F) |=> pc_r == $past(pc_r) + 16'h0040)
      else $error("largest forward offset wrong");

   // largest backward offset moves sixty-three words back
   AST_BACK_MAX: assert property (@(posedge clk_sys) disable iff (reset)
      s_take ##0 (req.offset == 7'h40) |=> pc_r == $past(pc_r) - 16'h003F)
      else $error("largest backward offset wrong");

   // the sequencer always sits in exactly one state
   AST_ONE_HOT: assert property (@(posedge clk_sys) disable iff (reset)
      $onehot(state_r))
      else $error("sequencer state not one-hot");

endmodule : conditional_branch_unit
`default_nettype wire

/* pkg/branch_pkg.sv */
// branch_pkg: shared types and constants for the conditional branch unit
// assumes a 16-bit word program counter and a 7-bit signed word offset
`default_nettype none
package branch_pkg;
   // ==========================================================
   // widths and reset values
   localparam int PC_W = 16;
   localparam int OFS_W = 7;
   localparam logic [15:0] PC_RESET = 16'h0000;
   localparam logic [15:0] PC_ONE = 16'h0001;
   // ==========================================================
   // branch kinds handed in by the decoder
   typedef enum logic [2:0] {
      BR_CARRY_CLEAR = 3'h0, // branch_on_carry_clear
      BR_AT_LEAST = 3'h1, // branch_unsigned_at_least
      BR_BELOW = 3'h2, // branch_unsigned_below
      BR_NEGATIVE = 3'h3, // branch_on_negative
      BR_NONNEG = 3'h4, // branch_on_nonnegative
      BR_SIGNED_GE = 3'h5 // branch_signed_at_least
   } branch_kind_t;
   // ==========================================================
   // decoded branch request
   typedef struct packed {
      logic valid;
      branch_kind_t kind;
      logic [6:0] offset;
   } branch_req_t;
   // status flags as seen by the unit
   typedef struct packed {
      logic carry;
      logic negative;
      logic overflow;
   } status_flags_t;
   // ==========================================================
   // sequencer states
   typedef enum logic [1:0] {
      ST_RUN = 2'b01,
      ST_FLUSH = 2'b10
   } seq_state_t;
endpackage : branch_pkg
`default_nettype wire

/* testbench/tb_top.sv */
// tb_top: self-checking bench for the conditional branch unit
// assumes branch_pkg is compiled first; inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; $display("MISMATCH %0t bad value", $time); end end
module tb_top
   import branch_pkg::*;
();
   // ==========================================================
   // stimulus and observed signals
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   branch_req_t req = '0;
   status_flags_t flags = '0;
   logic [15:0] pc;
   logic taken, flush, busy;
   logic [15:0] exp_pc = 16'h0000;
   int fails = 0;
   int tests_run = 0;
   int cycles = 0;
   conditional_branch_unit u_conditional_branch_unit (.clk_sys(clk_sys), .reset(reset), .req(req),
      .flags(flags), .pc(pc), .taken(taken), .flush(flush), .busy(busy));
   // ==========================================================
   // clock and hang guard
   initial begin
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles >= 2000) begin
         fails++;
         finish_test();
      end
   end
   // ==========================================================
   // one branch; request stays up so busy cycles see a refused request
   task automatic br(input branch_kind_t k, input logic [6:0] o, input logic [2:0] f, input logic tk);
      req = '{1'b1, k, o};
      flags = f;
      @(negedge clk_sys);
      exp_pc = tk ? exp_pc + {{9{o[6]}}, o} + 16'h0001 : exp_pc + 16'h0001;
      `CHK(pc, exp_pc)
      `CHK({taken, flush, busy}, {3{tk}})
      if (tk) begin
         @(negedge clk_sys);
         `CHK({pc, taken, flush, busy}, {exp_pc, 3'b000})
      end
   endtask : br
   task automatic s_carry;
      br(BR_CARRY_CLEAR, 7'h05, 3'b000, 1'b1);
      br(BR_CARRY_CLEAR, 7'h05, 3'b100, 1'b0);
      br(BR_AT_LEAST, 7'h7F, 3'b011, 1'b1);
      br(BR_AT_LEAST, 7'h3F, 3'b100, 1'b0);
      br(BR_BELOW, 7'h40, 3'b100, 1'b1);
      br(BR_BELOW, 7'h40, 3'b011, 1'b0);
   endtask : s_carry
   task automatic s_sign;
      br(BR_NEGATIVE, 7'h3F, 3'b010, 1'b1);
      br(BR_NEGATIVE, 7'h3F, 3'b101, 1'b0);
      br(BR_NONNEG, 7'h70, 3'b101, 1'b1);
      br(BR_NONNEG, 7'h70, 3'b010, 1'b0);
   endtask : s_sign
   task automatic s_signed_ge;
      for (int i = 0; i < 4; i++) begin
         br(BR_SIGNED_GE, 7'h21, {1'b0, 2'(i)}, ~(i[1] ^ i[0]));
      end
   endtask : s_signed_ge
   // unused kind codes fall through; an idle decoder leaves pc alone
   task automatic s_misc;
      br(branch_kind_t'(3'h6), 7'h12, 3'b000, 1'b0);
      br(branch_kind_t'(3'h7), 7'h12, 3'b111, 1'b0);
      req.valid = 1'b0;
      repeat (2) @(negedge clk_sys);
      `CHK({pc, taken, flush, busy}, {exp_pc, 3'b000})
   endtask : s_misc
   task automatic finish_test;
      if (fails == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test
   // ==========================================================
   // main sequence
   initial begin
      repeat (16) @(negedge clk_sys);
      reset = 1'b0;
      s_carry();
      s_sign();
      s_signed_ge();
      s_misc();
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
